// ---- rsl_pkg.sv ----
// Shared constants and types of the reset source logic
package rsl_pkg;

    // Timing
    localparam int CLK_PERIOD_NS      = 5;
    localparam int EXT_MIN_PULSE_NS   = 200;
    localparam int EXT_MIN_PULSE_CYC  = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_RESET_CYC       = 1;
    localparam int HOLD_RESET_CYC     = 4;

    // Register byte offsets
    localparam logic [3:0] OFS_CAUSE  = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK   = 4'h8;
    localparam logic [3:0] OFS_CTRL   = 4'hC;

    // Reset cause register fields
    localparam int CAUSE_TRAP_BIT = 15;
    localparam int CAUSE_EXT_BIT  = 7;
    localparam int CAUSE_SOFT_BIT = 6;
    localparam int CAUSE_WDT_BIT  = 4;
    localparam logic [15:0] CAUSE_IMPL  = 16'h80D0;
    localparam logic [15:0] CAUSE_RESET = 16'h0000;

    // Interrupt status and mask fields
    localparam int IRQ_W       = 5;
    localparam int IRQ_EXT_BIT  = 0;
    localparam int IRQ_SOFT_BIT = 1;
    localparam int IRQ_WDT_BIT  = 2;
    localparam int IRQ_TRAP_BIT = 3;
    localparam int IRQ_WAKE_BIT = 4;
    localparam logic [4:0] IRQ_RESET = 5'h00;

    // Control register fields
    localparam int CTRL_CLKSEL_LSB = 0;
    localparam int CLKSEL_W        = 2;
    localparam logic [1:0] CLKSEL_RESET = 2'h0;

    // Hard trap priority levels
    localparam logic [3:0] HARD_TRAP_MIN = 4'hD;
    localparam logic [3:0] HARD_TRAP_MAX = 4'hF;

    // Reset sequencer states
    typedef enum logic [1:0] {
        RSL_RUN   = 2'b00,
        RSL_EXT   = 2'b01,
        RSL_HOLD  = 2'b10,
        RSL_FETCH = 2'b11
    } rsl_state_e;

endpackage : rsl_pkg

// ---- rsl_glitch_filter.sv ----
// Glitch filter for the active-low external reset pin
module rsl_glitch_filter #(
    parameter int MIN_CYC = rsl_pkg::EXT_MIN_PULSE_CYC
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic pin_n,
    output logic      filt_low
);

    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          low_q;
    logic          low_d;

    // Count consecutive low samples; a high sample restarts the count
    always_comb begin
        cnt_d = cnt_q;
        low_d = low_q;
        if (pin_n) begin
            cnt_d = '0;
            low_d = 1'b0;
        end else if (cnt_q < CNT_MAX) begin
            cnt_d = cnt_q + CW'(1);
            low_d = (cnt_q == CNT_MAX - CW'(1));
        end
    end

    // Counter and filtered level
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            low_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            low_q <= low_d;
        end
    end

    assign filt_low = low_q;

    AST_FILT_HIGH_CLEARS: assert property (@(posedge core_clk) disable iff (!rstn)
        pin_n |=> !low_q) else $error("filter stays low after a high pin sample");
    AST_FILT_MIN_WIDTH: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(low_q) |-> $past(cnt_q) == CNT_MAX - CW'(1))
        else $error("filtered reset rose before the minimum low width");

endmodule : rsl_glitch_filter

// ---- rsl_reset_source.sv ----
// Reset source logic: pin, software, watchdog and trap-conflict resets with cause register
// Function
// - Low external pin resets the device
// - Short pin glitches are filtered out
// - Pin reset sets external-pin cause flag
// - Reset instruction asserts reset, keeps clock source
// - Software reset releases next cycle, fetches vector
// - Software reset sets cause bit 6
// - Running watchdog timeout resets, clock source kept
// - Watchdog timeout in sleep/idle only wakes
// - Watchdog reset sets cause bit 4
// - Lower hard trap during higher trap resets
// - Hard traps are priority levels 13 to 15
// - Trap conflict reset sets cause bit 15
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
module rsl_reset_source #(
    parameter int SW_CYC   = rsl_pkg::SW_RESET_CYC,
    parameter int HOLD_CYC = rsl_pkg::HOLD_RESET_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        reset_instr,
    input  wire logic        watchdog_timeout,
    input  wire logic        cpu_sleep,
    input  wire logic        cpu_idle,
    input  wire logic        hard_trap_req,
    input  wire logic [3:0]  hard_trap_level,
    input  wire logic [3:0]  active_trap_level,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             system_reset,
    output logic             vector_fetch,
    output logic             wake_req,
    output logic [1:0]       clk_src_sel,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam logic [3:0] SW_CNT   = 4'(SW_CYC);
    localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);

    rsl_pkg::rsl_state_e state_q;
    rsl_pkg::rsl_state_e state_d;
    logic [3:0]          cnt_q;
    logic [3:0]          cnt_d;
    logic                system_reset_q;
    logic                system_reset_d;
    logic                fetch_q;
    logic                fetch_d;
    logic                wake_q;
    logic                wake_d;
    logic [15:0]         cause_q;
    logic [15:0]         cause_d;
    logic [4:0]          stat_q;
    logic [4:0]          stat_d;
    logic [4:0]          mask_q;
    logic [4:0]          mask_d;
    logic [1:0]          clksel_q;
    logic [1:0]          clksel_d;
    logic [31:0]         rdata_q;
    logic [31:0]         rdata_d;
    logic                wait_q;
    logic                wait_d;
    logic                irq_q;
    logic                irq_d;
    logic                ext_low;
    logic                running;
    logic                wdt_asleep;
    logic                ev_ext;
    logic                ev_soft;
    logic                ev_wdt;
    logic                ev_trap;
    logic                ev_wake;
    logic                trap_conflict;
    logic                wr_go;
    logic [31:0]         wmask;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin filter

    rsl_glitch_filter #(
        .MIN_CYC (rsl_pkg::EXT_MIN_PULSE_CYC)
    ) u_filter (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_n    (ext_reset_pin_n),
        .filt_low (ext_low)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reset events

    // Only hard traps can conflict, and only under a higher-priority trap
    assign trap_conflict = hard_trap_req
                        && hard_trap_level >= rsl_pkg::HARD_TRAP_MIN
                        && hard_trap_level <= rsl_pkg::HARD_TRAP_MAX
                        && hard_trap_level < active_trap_level;
    // Events other than the pin reset are refused until the reset left over from rstn has dropped
    assign running    = (state_q == rsl_pkg::RSL_RUN) && !system_reset_q;
    assign wdt_asleep = cpu_sleep || cpu_idle;
    assign ev_ext     = ext_low && (state_q != rsl_pkg::RSL_EXT);
    assign ev_wdt     = running && !ext_low && watchdog_timeout && !wdt_asleep;
    assign ev_wake    = running && !ext_low && watchdog_timeout && wdt_asleep;
    assign ev_trap    = running && !ext_low && !ev_wdt && trap_conflict;
    assign ev_soft    = running && !ext_low && !ev_wdt && !ev_trap && reset_instr;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // Pin reset wins, then watchdog, trap conflict and reset instruction
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        system_reset_d = system_reset_q;
        fetch_d  = 1'b0;
        wake_d   = ev_wake;
        if (ext_low) begin
            state_d  = rsl_pkg::RSL_EXT;
            system_reset_d = 1'b1;
        end else begin
            case (state_q)
                rsl_pkg::RSL_RUN: begin
                    system_reset_d = 1'b0;  // Release the power-on reset at the first edge
                    if (ev_wdt || ev_trap) begin
                        state_d  = rsl_pkg::RSL_HOLD;
                        cnt_d    = HOLD_CNT;
                        system_reset_d = 1'b1;
                    end else if (ev_soft) begin
                        state_d  = rsl_pkg::RSL_HOLD;
                        cnt_d    = SW_CNT;
                        system_reset_d = 1'b1;
                    end
                end
                rsl_pkg::RSL_EXT: begin
                    state_d  = rsl_pkg::RSL_FETCH;
                    system_reset_d = 1'b0;
                    fetch_d  = 1'b1;
                end
                rsl_pkg::RSL_HOLD: begin
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q <= 4'h1) begin
                        state_d  = rsl_pkg::RSL_FETCH;
                        system_reset_d = 1'b0;
                        fetch_d  = 1'b1;
                    end
                end
                default: begin
                    state_d = rsl_pkg::RSL_RUN;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q  <= rsl_pkg::RSL_RUN;
            cnt_q    <= 4'h0;
            system_reset_q <= 1'b1;
            fetch_q  <= 1'b0;
            wake_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            system_reset_q <= system_reset_d;
            fetch_q  <= fetch_d;
            wake_q   <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and bus slave

    assign wr_go = avs_write && !wait_q;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Writes commit at the accepting edge; hardware sets win over clears
    always_comb begin
        cause_d  = cause_q;
        stat_d   = stat_q;
        mask_d   = mask_q;
        clksel_d = clksel_q;
        rdata_d  = 32'h0000_0000;
        wait_d   = !((avs_read || avs_write) && wait_q);
        if (wr_go) begin
            if (avs_address == rsl_pkg::OFS_CAUSE) begin
                cause_d = (cause_q & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]
                          & rsl_pkg::CAUSE_IMPL);
            end else if (avs_address == rsl_pkg::OFS_STATUS) begin
                stat_d = stat_q & ~(avs_writedata[4:0] & wmask[4:0]);
            end else if (avs_address == rsl_pkg::OFS_MASK) begin
                mask_d = (mask_q & ~wmask[4:0]) | (avs_writedata[4:0] & wmask[4:0]);
            end else if (avs_address == rsl_pkg::OFS_CTRL) begin
                clksel_d = (clksel_q & ~wmask[1:0])
                         | (avs_writedata[rsl_pkg::CTRL_CLKSEL_LSB +: rsl_pkg::CLKSEL_W] & wmask[1:0]);
            end
        end
        if (avs_read && wait_q) begin
            if (avs_address == rsl_pkg::OFS_CAUSE) begin
                rdata_d = {16'h0000, cause_q};
            end else if (avs_address == rsl_pkg::OFS_STATUS) begin
                rdata_d = {27'h0, stat_q};
            end else if (avs_address == rsl_pkg::OFS_MASK) begin
                rdata_d = {27'h0, mask_q};
            end else if (avs_address == rsl_pkg::OFS_CTRL) begin
                rdata_d = {30'h0, clksel_q};
            end
        end
        // A pin reset reloads the clock source; other resets keep it
        if (ev_ext) begin
            clksel_d = rsl_pkg::CLKSEL_RESET;
        end
        if (ev_ext) begin
            cause_d[rsl_pkg::CAUSE_EXT_BIT] = 1'b1;
        end
        if (ev_soft) begin
            cause_d[rsl_pkg::CAUSE_SOFT_BIT] = 1'b1;
        end
        if (ev_wdt) begin
            cause_d[rsl_pkg::CAUSE_WDT_BIT] = 1'b1;
        end
        if (ev_trap) begin
            cause_d[rsl_pkg::CAUSE_TRAP_BIT] = 1'b1;
        end
        stat_d = stat_d | {ev_wake, ev_trap, ev_wdt, ev_soft, ev_ext};
        irq_d  = |(stat_d & mask_d);
    end

    // Register file and bus registers; rstn clears them except wait_q, which it sets, and a pin reset also reloads clksel_q
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cause_q  <= rsl_pkg::CAUSE_RESET;
            stat_q   <= rsl_pkg::IRQ_RESET;
            mask_q   <= rsl_pkg::IRQ_RESET;
            clksel_q <= rsl_pkg::CLKSEL_RESET;
            rdata_q  <= 32'h0000_0000;
            wait_q   <= 1'b1;
            irq_q    <= 1'b0;
        end else begin
            cause_q  <= cause_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            clksel_q <= clksel_d;
            rdata_q  <= rdata_d;
            wait_q   <= wait_d;
            irq_q    <= irq_d;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign system_reset    = system_reset_q;
    assign vector_fetch    = fetch_q;
    assign wake_req        = wake_q;
    assign clk_src_sel     = clksel_q;
    assign irq             = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_soft_pulse;
        system_reset ##1 (!system_reset && vector_fetch);
    endsequence

    sequence s_hold_release;
        system_reset [*4] ##1 (!system_reset && vector_fetch);
    endsequence

    AST_EXT_RESET: assert property (@(posedge core_clk) disable iff (!rstn)
        ext_low |=> system_reset) else $error("pin reset not asserted");
    AST_EXT_FLAG: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(ext_low) |=> cause_q[rsl_pkg::CAUSE_EXT_BIT])
        else $error("external pin flag not set");
    AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (!rstn)
        (running && !ext_low && reset_instr && !watchdog_timeout && !trap_conflict
         && !$rose(ext_low)) ##1 !ext_low |-> s_soft_pulse)
        else $error("software reset not one cycle");
    AST_SOFT_FLAG: assert property (@(posedge core_clk) disable iff (!rstn)
        ev_soft |=> cause_q[rsl_pkg::CAUSE_SOFT_BIT]) else $error("soft reset flag not set");
    // A pin reset arriving during the hold takes over, so it ends the check
    AST_WDT_RESET: assert property (@(posedge core_clk) disable iff (!rstn || ext_low)
        ev_wdt |=> s_hold_release) else $error("watchdog reset length wrong");
    AST_WDT_WAKE: assert property (@(posedge core_clk) disable iff (!rstn)
        (running && watchdog_timeout && wdt_asleep && !ext_low && !trap_conflict && !reset_instr)
        |=> (wake_req && !system_reset))
        else $error("watchdog in sleep must wake, not reset");
    AST_WDT_FLAG: assert property (@(posedge core_clk) disable iff (!rstn)
        ev_wdt |=> cause_q[rsl_pkg::CAUSE_WDT_BIT]) else $error("watchdog flag not set");
    AST_TRAP_RESET: assert property (@(posedge core_clk) disable iff (!rstn)
        ev_trap |=> (system_reset && cause_q[rsl_pkg::CAUSE_TRAP_BIT]))
        else $error("trap conflict reset or flag missing");
    AST_SOFT_TRAP_LEVEL: assert property (@(posedge core_clk) disable iff (!rstn)
        (running && !ext_low && hard_trap_req && hard_trap_level < rsl_pkg::HARD_TRAP_MIN
         && !watchdog_timeout && !reset_instr) |=> !system_reset)
        else $error("non-hard trap caused a reset");
    AST_CLK_KEPT: assert property (@(posedge core_clk) disable iff (!rstn)
        (system_reset && !ext_low && !$past(ev_ext) && !$past(wr_go)) |-> $stable(clk_src_sel))
        else $error("clock source changed by a non-pin reset");
    AST_CAUSE_KEPT: assert property (@(posedge core_clk) disable iff (!rstn)
        (system_reset && !$past(wr_go)) |-> ((cause_q & $past(cause_q)) == $past(cause_q)))
        else $error("cause flag lost during reset");

endmodule : rsl_reset_source

// ---- rsl_partner.sv ----
// Model of the reset supervisor on the pin and of the core fetching the reset vector
module rsl_partner (
    input  wire logic       core_clk,
    input  wire logic       start,
    input  wire logic [7:0] low_len,
    input  wire logic       vector_fetch,
    output logic            ext_reset_pin_n,
    output int              n_fetch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;

    initial begin
        cnt_q   = 8'h00;
        n_fetch = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Supervisor holds the pin low for the commanded number of cycles
    always @(posedge core_clk) begin
        if (start) begin
            cnt_q <= low_len;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign ext_reset_pin_n = (cnt_q == 8'h00);

    ////////////////////////////////////////////////////////////////////////////////
    // Core counts every reset-vector fetch it is told to start
    always @(posedge core_clk) begin
        if (vector_fetch === 1'b1) begin
            n_fetch <= n_fetch + 1;
        end
    end
endmodule : rsl_partner

// ---- tb_top.sv ----
// Self-checking testbench of the reset source logic
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} rsl_row_s;
    logic        core_clk, rstn, reset_instr, watchdog_timeout, cpu_sleep, cpu_idle;
    logic        hard_trap_req, ext_reset_pin_n, avs_read, avs_write, avs_waitrequest;
    logic        system_reset, vector_fetch, wake_req, irq, start;
    logic [3:0]  hard_trap_level, active_trap_level, avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0]  clk_src_sel;
    logic [7:0]  low_len;
    int          n_fetch, miscompares, n_checks, hi;
    rsl_row_s    rows [5] = '{'{4'hC, 32'hFFFFFFFF, 32'h3}, '{4'h8, 32'hFFFFFFFF, 32'h1F},
                              '{4'h8, 32'h0, 32'h0}, '{4'h2, 32'hFFFFFFFF, 32'h0}, '{4'hC, 32'h2, 32'h2}};
    logic [3:0]  tl [7] = '{4'hD, 4'hE, 4'hD, 4'hC, 4'hF, 4'hE, 4'hD};
    logic [3:0]  ta [7] = '{4'hE, 4'hF, 4'hF, 4'hF, 4'hF, 4'hD, 4'h0};
    int          th [7] = '{4, 4, 4, 0, 0, 0, 0};

    rsl_reset_source i_rsl_reset_source (.core_clk(core_clk), .rstn(rstn), .ext_reset_pin_n(ext_reset_pin_n),
        .reset_instr(reset_instr), .watchdog_timeout(watchdog_timeout), .cpu_sleep(cpu_sleep),
        .cpu_idle(cpu_idle), .hard_trap_req(hard_trap_req), .hard_trap_level(hard_trap_level),
        .active_trap_level(active_trap_level), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .system_reset(system_reset),
        .vector_fetch(vector_fetch), .wake_req(wake_req), .clk_src_sel(clk_src_sel), .irq(irq));
    rsl_partner i_rsl_partner (.core_clk(core_clk), .start(start), .low_len(low_len),
        .vector_fetch(vector_fetch), .ext_reset_pin_n(ext_reset_pin_n), .n_fetch(n_fetch));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #50us;
        miscompares++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bus access: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk(n, 2);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    // One-cycle event: 0 instruction, 1 watchdog, 2 trap, 3 pin pulse
    task automatic fire(input int k);
        case (k)
            0: reset_instr <= 1'b1;
            1: watchdog_timeout <= 1'b1;
            2: hard_trap_req <= 1'b1;
            default: start <= 1'b1;
        endcase
        @(posedge core_clk);
        reset_instr      <= 1'b0;
        watchdog_timeout <= 1'b0;
        hard_trap_req    <= 1'b0;
        start            <= 1'b0;
    endtask : fire

    // Count cycles of reset held before the vector fetch pulse
    task automatic meas(output int h);
        h = 0;
        repeat (100) begin
            @(posedge core_clk);
            if (vector_fetch === 1'b1) break;
            if (system_reset === 1'b1) h++;
        end
    endtask : meas

    task report_and_stop;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rstn, reset_instr, watchdog_timeout, cpu_sleep, cpu_idle, hard_trap_req, start} = '0;
        {avs_read, avs_write, avs_address, avs_writedata, hard_trap_level, active_trap_level} = '0;
        avs_byteenable = 4'hF;
        low_len        = 8'h00;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(system_reset, 1'b0);
        chk(irq, 1'b0);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(4'h8, 32'h4);
        // Software reset keeps the clock source
        fire(0);
        meas(hi);
        chk(hi, 1);
        chk(clk_src_sel, 2'h2);
        rd(4'h0, 32'h40);
        chk(irq, 1'b0);
        // Watchdog reset while running
        fire(1);
        meas(hi);
        chk(hi, 4);
        chk(clk_src_sel, 2'h2);
        rd(4'h0, 32'h50);
        chk(irq, 1'b1);
        wr(4'h4, 32'h4);
        rd(4'h4, 32'h2);
        chk(irq, 1'b0);
        wr(4'h0, 32'h0);
        rd(4'h0, 32'h0);
        // Watchdog in sleep and idle only wakes
        for (int j = 0; j < 2; j++) begin
            cpu_sleep <= (j == 0);
            cpu_idle  <= (j == 1);
            @(posedge core_clk);
            fire(1);
            @(posedge core_clk);
            chk(wake_req, 1'b1);
            chk(system_reset, 1'b0);
        end
        cpu_sleep <= 1'b0;
        cpu_idle  <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h12);
        // Trap conflicts across hard and ordinary levels
        foreach (tl[i]) begin
            hard_trap_level   <= tl[i];
            active_trap_level <= ta[i];
            fire(2);
            meas(hi);
            chk(hi, th[i]);
        end
        rd(4'h0, 32'h8000);
        // Pin glitch one cycle short, then a long pulse
        low_len <= 8'd39;
        fire(3);
        meas(hi);
        chk(hi, 0);
        low_len <= 8'd60;
        fire(3);
        meas(hi);
        chk(hi > 0, 1'b1);
        chk(clk_src_sel, 2'h0);
        rd(4'h0, 32'h8080);
        chk(n_fetch, 6);
        // Disabled byte lane blocks the write, then a full write lands
        avs_byteenable <= 4'hE;
        wr(4'hC, 32'h1);
        avs_byteenable <= 4'hF;
        rd(4'hC, 32'h0);
        wr(4'hC, 32'h1);
        rd(4'hC, 32'h1);
        // Power-on reset in mid-run clears the registers
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(4'h0, 32'h0);
        rd(4'hC, 32'h0);
        chk(system_reset, 1'b0);
        report_and_stop();
    end
endmodule : tb_top
